// File: design/bws_pkg.sv
package bws_pkg;
    // register byte addresses on the apb bus
    localparam logic [15:0] ADDR_GPIO = 16'hfff4;
    localparam logic [15:0] ADDR_CTRL = 16'hfff8;
    localparam logic [15:0] ADDR_STAT = 16'hfffc;
    // stretch_control_reg layout
    localparam int CTRL_CNT_LSB = 0;
    localparam int CTRL_MODE_LSB = 2;
    localparam logic [3:0] CTRL_RESET = 4'h3;
    localparam logic [3:0] CTRL_RSVD = 4'hf;
    // gpio register layout
    localparam int GPIO_DATA_BIT = 0;
    localparam int GPIO_DIR_BIT = 1;
    localparam int GPIO_PIN_BIT = 2;
    localparam logic [1:0] GPIO_RESET = 2'h0;
    // wait-mode select encodings
    localparam logic [1:0] MODE_FIXED = 2'h0;
    localparam logic [1:0] MODE_NONE = 2'h1;
    localparam logic [1:0] MODE_PIN = 2'h2;
    localparam logic [1:0] MODE_AUTO = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_TW,
        ST_T3
    } bws_state_t;

    // one-hot view of the bus cycle
    typedef struct packed {
        logic t1;
        logic t2;
        logic tw;
        logic t3;
    } bws_cycle_t;

    // control register contents
    typedef struct packed {
        logic modeSelectHi;
        logic modeSelectLo;
        logic countBitHi;
        logic countBitLo;
    } bws_ctrl_t;
endpackage

// File: design/bws_sync.sv
`timescale 1ns/1ps
module bws_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // asynchronous level in, synchronous level out
    input wire logic asyncIn,
    output logic syncOut
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // first stage feeds only the second
    always_comb begin
        meta_d = asyncIn;
        sync_d = meta_q;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign syncOut = sync_q;
endmodule

// File: design/bws_down_counter.sv
`timescale 1ns/1ps
module bws_down_counter #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    input wire logic dec,
    // state
    output logic [WIDTH-1:0] count,
    output logic lastOrZero
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    // load wins over decrement; saturates at zero
    always_comb begin
        count_d = count_q;
        if (load) begin
            count_d = loadValue;
        end else if (dec && count_q != '0) begin
            count_d = count_q - WIDTH'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign count = count_q;
    assign lastOrZero = (count_q <= WIDTH'(1));
endmodule

// File: design/bws_wait_ctrl.sv
`timescale 1ns/1ps
//
// Contract
// - mode bits 00 select fixed-count mode
// - fixed mode inserts exactly the programmed count
// - fixed mode ignores wait pin; pin stays gpio
// - mode bits 10 select pin-extended mode
// - pin mode adds states while pin low
// - pin mode, count zero, low pin extends
// - mode bits 11 select decode-triggered mode
// - pin modes switch shared pin to wait input
// - decode mode inserts count only if pin low
// - decode mode samples pin once in T2
// - decode mode ignores pin in extension, T3
// - count 00/01/10/11 gives 0/1/2/3 states
// - mode bits 01 insert no states ever
// - extension states sit between T2 and T3
// - on-chip accesses are never extended
module bws_wait_ctrl #(
    parameter int CNT_W = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bus cycle from the processor or transfer_controller
    input wire logic accessStart,
    input wire logic accessExternal,
    output bws_pkg::bws_cycle_t cycle,
    // shared_port_pin
    input wire logic sharedPinIn,
    output logic sharedPinOut,
    output logic sharedPinOe,
    output logic waitFuncSel
);
    // apb and register state
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    bws_pkg::bws_ctrl_t ctrl_q;
    bws_pkg::bws_ctrl_t ctrl_d;
    logic [1:0] gpio_q;
    logic [1:0] gpio_d;
    // bus-cycle state
    bws_pkg::bws_state_t state_q;
    bws_pkg::bws_state_t state_d;
    logic external_q;
    logic external_d;
    bws_pkg::bws_cycle_t cycle_q;
    bws_pkg::bws_cycle_t cycle_d;
    logic pinOut_q;
    logic pinOut_d;
    logic pinOe_q;
    logic pinOe_d;
    logic waitFunc_q;
    logic waitFunc_d;
    // helpers
    logic [1:0] mode;
    logic [CNT_W-1:0] waitCount;
    logic pinSync;
    logic waitLow;
    logic cntLoad;
    logic [CNT_W-1:0] cntLoadValue;
    logic cntDec;
    logic [CNT_W-1:0] cnt;
    logic cntLast;
    logic accessPhase;
    logic takeAccess;

    assign mode = {ctrl_q.modeSelectHi, ctrl_q.modeSelectLo};
    assign waitCount = CNT_W'({ctrl_q.countBitHi, ctrl_q.countBitLo});

    // pin comes from outside the clock domain
    bws_sync #(
        .RESET_VAL(1'b1)
    ) uPinSync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(sharedPinIn),
        .syncOut(pinSync)
    );

    // wait only counts while the pin is in its wait role
    assign waitLow = waitFunc_q & ~pinSync;

    // apb: one idle access cycle, answer on the second
    assign accessPhase = psel & penable;
    assign takeAccess = accessPhase & pready_q;

    always_comb begin
        pready_d = accessPhase & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        ctrl_d = ctrl_q;
        gpio_d = gpio_q;
        if (accessPhase && !pready_q) begin
            case (paddr)
                bws_pkg::ADDR_CTRL: begin
                    prdata_d = {24'h00_0000, bws_pkg::CTRL_RSVD, ctrl_q};
                end
                bws_pkg::ADDR_GPIO: begin
                    prdata_d[bws_pkg::GPIO_DATA_BIT] = gpio_q[0];
                    prdata_d[bws_pkg::GPIO_DIR_BIT] = gpio_q[1];
                    prdata_d[bws_pkg::GPIO_PIN_BIT] = pinSync;
                end
                bws_pkg::ADDR_STAT: begin
                    prdata_d[3:0] = cycle_q;
                    prdata_d[4 +: CNT_W] = cnt;
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
        // writes land only at the completing edge
        if (takeAccess && pwrite) begin
            case (paddr)
                bws_pkg::ADDR_CTRL: begin
                    ctrl_d = pwdata[3:0];
                end
                bws_pkg::ADDR_GPIO: begin
                    gpio_d = pwdata[1:0];
                end
                default: begin
                    gpio_d = gpio_q;
                end
            endcase
        end
    end

    // no standby input: only rst_b touches the control bits
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            ctrl_q <= bws_pkg::CTRL_RESET;
            gpio_q <= bws_pkg::GPIO_RESET;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            ctrl_q <= ctrl_d;
            gpio_q <= gpio_d;
        end
    end

    // extension counter, loaded while in T2
    always_comb begin
        cntLoad = (state_q == bws_pkg::ST_T2);
        cntDec = (state_q == bws_pkg::ST_TW);
        cntLoadValue = '0;
        if (external_q) begin
            case (mode)
                bws_pkg::MODE_FIXED: cntLoadValue = waitCount;
                bws_pkg::MODE_PIN: cntLoadValue = waitCount;
                bws_pkg::MODE_AUTO: cntLoadValue = waitLow ? waitCount : '0;
                default: cntLoadValue = '0;
            endcase
        end
    end

    bws_down_counter #(
        .WIDTH(CNT_W)
    ) uCounter (
        .clk(clk),
        .rst_b(rst_b),
        .load(cntLoad),
        .loadValue(cntLoadValue),
        .dec(cntDec),
        .count(cnt),
        .lastOrZero(cntLast)
    );

    // bus-cycle sequencer: T1, T2, extension states, T3
    always_comb begin
        state_d = state_q;
        external_d = external_q;
        case (state_q)
            bws_pkg::ST_IDLE: begin
                if (accessStart) begin
                    state_d = bws_pkg::ST_T1;
                    external_d = accessExternal;
                end
            end
            bws_pkg::ST_T1: begin
                state_d = bws_pkg::ST_T2;
            end
            bws_pkg::ST_T2: begin
                // pin seen once here; decode mode never looks again
                state_d = bws_pkg::ST_T3;
                if (cntLoadValue != '0) begin
                    state_d = bws_pkg::ST_TW;
                end else if (external_q && mode == bws_pkg::MODE_PIN && waitLow) begin
                    state_d = bws_pkg::ST_TW;
                end
            end
            bws_pkg::ST_TW: begin
                // only pin mode keeps looking at the pin
                if (cntLast && !(mode == bws_pkg::MODE_PIN && waitLow)) begin
                    state_d = bws_pkg::ST_T3;
                end
            end
            bws_pkg::ST_T3: begin
                state_d = bws_pkg::ST_IDLE;
                if (accessStart) begin
                    state_d = bws_pkg::ST_T1;
                    external_d = accessExternal;
                end
            end
            default: begin
                state_d = bws_pkg::ST_IDLE;
            end
        endcase
    end

    // outputs decoded from next state so they leave a flop
    always_comb begin
        cycle_d.t1 = (state_d == bws_pkg::ST_T1);
        cycle_d.t2 = (state_d == bws_pkg::ST_T2);
        cycle_d.tw = (state_d == bws_pkg::ST_TW);
        cycle_d.t3 = (state_d == bws_pkg::ST_T3);
        waitFunc_d = ctrl_d.modeSelectHi;
        pinOut_d = gpio_d[0];
        pinOe_d = gpio_d[1] & ~ctrl_d.modeSelectHi;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= bws_pkg::ST_IDLE;
            external_q <= 1'b0;
            cycle_q <= '0;
            waitFunc_q <= 1'b0;
            pinOut_q <= 1'b0;
            pinOe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            external_q <= external_d;
            cycle_q <= cycle_d;
            waitFunc_q <= waitFunc_d;
            pinOut_q <= pinOut_d;
            pinOe_q <= pinOe_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cycle = cycle_q;
    assign sharedPinOut = pinOut_q;
    assign sharedPinOe = pinOe_q;
    assign waitFuncSel = waitFunc_q;

    // checks on the sequencer
    logic inT2;
    logic inTw;
    assign inT2 = (state_q == bws_pkg::ST_T2);
    assign inTw = (state_q == bws_pkg::ST_TW);

    AST_FIXED_TWO: assert property (@(posedge clk) disable iff (!rst_b)
        inT2 && external_q && mode == bws_pkg::MODE_FIXED && waitCount == 2'h2
        |=> cycle_q.tw ##1 cycle_q.tw ##1 cycle_q.t3)
        else $error("fixed mode count two not honoured");

    AST_FIXED_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        inT2 && mode == bws_pkg::MODE_FIXED && waitCount == 2'h0 |=> cycle_q.t3)
        else $error("count zero still extended");

    // pin role flops load from ctrl_d, so they track ctrl_q in the same cycle
    AST_PIN_GPIO: assert property (@(posedge clk) disable iff (!rst_b)
        mode == bws_pkg::MODE_FIXED |-> (!waitFuncSel && sharedPinOe == gpio_q[1]))
        else $error("shared pin not gpio in fixed mode");

    AST_PIN_FUNC: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_q.modeSelectHi |-> (waitFuncSel && !sharedPinOe))
        else $error("pin mode did not take the shared pin");

    AST_PIN_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        inTw && mode == bws_pkg::MODE_PIN && waitLow |=> cycle_q.tw)
        else $error("low pin did not hold extension");

    AST_PIN_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        inT2 && external_q && mode == bws_pkg::MODE_PIN && waitCount == 2'h0 && waitLow
        |=> cycle_q.tw)
        else $error("pin mode count zero ignored low pin");

    AST_AUTO_SKIP: assert property (@(posedge clk) disable iff (!rst_b)
        inT2 && mode == bws_pkg::MODE_AUTO && !waitLow |=> cycle_q.t3)
        else $error("decode mode extended without low pin");

    AST_AUTO_ONCE: assert property (@(posedge clk) disable iff (!rst_b)
        inT2 && external_q && mode == bws_pkg::MODE_AUTO && waitLow && waitCount == 2'h1
        ##1 $stable(ctrl_q) |-> cycle_q.tw ##1 cycle_q.t3)
        else $error("decode mode added states after sample");

    AST_NONE_MODE: assert property (@(posedge clk) disable iff (!rst_b)
        inT2 && mode == bws_pkg::MODE_NONE |=> cycle_q.t3)
        else $error("mode 01 inserted states");

    AST_ONCHIP: assert property (@(posedge clk) disable iff (!rst_b)
        inT2 && !external_q |=> cycle_q.t3)
        else $error("on-chip access extended");

    AST_PLACEMENT: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(cycle_q.tw) |-> $past(cycle_q.t2))
        else $error("extension not after second_bus_state");

    AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_b)
        inTw && cntLast && mode != bws_pkg::MODE_PIN |=> cycle_q.t3)
        else $error("counter done but cycle not released");

    // the sequencer never shows two bus states at once
    AST_ONE_HOT: assert property (@(posedge clk) disable iff (!rst_b)
        $onehot0(cycle_q))
        else $error("bus state view not one-hot");

    // count is taken in second_bus_state and nowhere else
    AST_LOAD_T2: assert property (@(posedge clk) disable iff (!rst_b)
        inT2 |=> cnt == $past(cntLoadValue))
        else $error("counter not loaded in second_bus_state");

    // a pin still low in extension must not stretch decode mode
    AST_AUTO_LATE: assert property (@(posedge clk) disable iff (!rst_b)
        inTw && mode == bws_pkg::MODE_AUTO && waitLow && cntLast |=> cycle_q.t3)
        else $error("decode mode held by late low pin");

    COV_FIXED3: cover property (@(posedge clk) disable iff (!rst_b)
        cycle_q.t2 ##1 cycle_q.tw [*3] ##1 cycle_q.t3);
    COV_PIN_LONG: cover property (@(posedge clk) disable iff (!rst_b)
        mode == bws_pkg::MODE_PIN && cycle_q.tw [*5] ##1 cycle_q.t3);
    COV_AUTO_HIT: cover property (@(posedge clk) disable iff (!rst_b)
        mode == bws_pkg::MODE_AUTO && cycle_q.t2 ##1 cycle_q.tw);
    COV_AUTO_ONE: cover property (@(posedge clk) disable iff (!rst_b)
        mode == bws_pkg::MODE_AUTO && cycle_q.t2 ##1 cycle_q.tw ##1 cycle_q.t3);
endmodule

// File: testbench/bws_ext_dev.sv
`timescale 1ns/1ps
module bws_ext_dev (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // bus cycle seen at the device
    input wire bws_pkg::bws_cycle_t cycle,
    // address decode and requested extension length
    input wire logic decodeHit,
    input wire logic [7:0] holdTw,
    // open-drain wait request, pull-up when released
    output logic pinLow
);
    logic [7:0] twSeen_q;

    // counts extension states; cleared only while no bus state shows, so an access after an idle cycle starts fresh
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            twSeen_q <= 8'h00;
        end else if (cycle == 4'h0) begin
            twSeen_q <= 8'h00;
        end else if (cycle.tw) begin
            twSeen_q <= twSeen_q + 8'h01;
        end
    end

    // decode pulls the line low ahead of the second state, released after hold
    assign pinLow = decodeHit && (twSeen_q < holdTw);
endmodule

// File: testbench/bws_wait_ctrl_tb_top.sv
`timescale 1ns/1ps
module bws_wait_ctrl_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic accessStart = 1'b0;
    logic accessExternal = 1'b0;
    bws_pkg::bws_cycle_t cycle;
    logic sharedPinOut;
    logic sharedPinOe;
    logic waitFuncSel;
    logic pinLow;
    logic pinWire;
    logic decodeHit = 1'b0;
    logic [7:0] holdTw = 8'h00;
    int err_total = 0;
    int tests_run = 0;
    int clkCount = 0;
    logic [31:0] rd;
    logic er;

    always #5 clk = ~clk;

    // pin level: our gpio drive wins, else the device pulls low, else pull-up
    assign pinWire = sharedPinOe ? sharedPinOut : !pinLow;

    bws_wait_ctrl #(.CNT_W(2)) bws_wait_ctrl_i (
        .clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .accessStart(accessStart), .accessExternal(accessExternal),
        .cycle(cycle), .sharedPinIn(pinWire), .sharedPinOut(sharedPinOut),
        .sharedPinOe(sharedPinOe), .waitFuncSel(waitFuncSel)
    );

    bws_ext_dev bws_ext_dev_i (
        .clk(clk), .rst_b(rst_b), .cycle(cycle), .decodeHit(decodeHit),
        .holdTw(holdTw), .pinLow(pinLow)
    );

    task automatic stop_test;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n >= 20) begin
            err_total++;
            $display("ERROR %0t apb transfer never completed", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_ctrl(input logic [1:0] mode, input logic [1:0] cnt);
        apb(1'b1, bws_pkg::ADDR_CTRL, {28'h0, mode, cnt});
        apb(1'b0, bws_pkg::ADDR_CTRL, 32'h0);
        check(rd, {24'h0, 4'hf, mode, cnt});
        check(waitFuncSel, mode[1]);
    endtask

    // one bus cycle; extension count must fall in [lo,hi] and sit before t3
    task automatic run_cycle(input logic ext, input int lo, input int hi);
        int tw;
        int n;
        bws_pkg::bws_cycle_t prev;
        tw = 0;
        prev = 4'h0;
        @(posedge clk);
        accessExternal <= ext;
        accessStart <= 1'b1;
        @(posedge clk);
        accessStart <= 1'b0;
        for (n = 0; n < 40; n++) begin
            #1;
            if (cycle.tw) begin
                tw++;
                check(prev.t2 | prev.tw, 1'b1);
            end
            if (cycle.t3) begin
                check(tw > 0 ? prev.tw : prev.t2, 1'b1);
                break;
            end
            prev = cycle;
            @(posedge clk);
        end
        check(n < 40, 1'b1);
        check(tw >= lo && tw <= hi, 1'b1);
        @(posedge clk);
    endtask

    // reset value, gpio use of the pin, unmapped address
    task automatic test_reset_gpio;
        apb(1'b0, bws_pkg::ADDR_CTRL, 32'h0);
        check(rd, 32'h000000f3);
        run_cycle(1'b1, 3, 3);
        apb(1'b1, bws_pkg::ADDR_GPIO, 32'h3);
        #1;
        check({sharedPinOe, sharedPinOut}, 2'h3);
        repeat (4) @(posedge clk);
        apb(1'b0, bws_pkg::ADDR_GPIO, 32'h0);
        check(rd[2:0], 3'h7);
        apb(1'b1, bws_pkg::ADDR_GPIO, 32'h0);
        apb(1'b0, 16'h0000, 32'h0);
        check({er, rd}, {1'b1, 32'h0});
    endtask

    // fixed mode ignores a held-low pin; on-chip access never stretched
    task automatic test_fixed;
        int c;
        decodeHit <= 1'b1;
        holdTw <= 8'd50;
        for (c = 0; c < 4; c++) begin
            set_ctrl(bws_pkg::MODE_FIXED, c[1:0]);
            run_cycle(1'b1, c, c);
        end
        run_cycle(1'b0, 0, 0);
        set_ctrl(bws_pkg::MODE_NONE, 2'h3);
        run_cycle(1'b1, 0, 0);
        decodeHit <= 1'b0;
    endtask

    // pin mode: count alone, then pin stretching a zero count
    task automatic test_pin;
        set_ctrl(bws_pkg::MODE_PIN, 2'h2);
        apb(1'b1, bws_pkg::ADDR_GPIO, 32'h3);
        #1;
        check(sharedPinOe, 1'b0);
        apb(1'b1, bws_pkg::ADDR_GPIO, 32'h0);
        run_cycle(1'b1, 2, 2);
        set_ctrl(bws_pkg::MODE_PIN, 2'h0);
        holdTw <= 8'd4;
        decodeHit <= 1'b1;
        repeat (4) @(posedge clk);
        run_cycle(1'b1, 4, 8);
        decodeHit <= 1'b0;
    endtask

    // decode mode: high pin gives none, low pin gives exactly the count
    task automatic test_decode;
        set_ctrl(bws_pkg::MODE_AUTO, 2'h2);
        run_cycle(1'b1, 0, 0);
        holdTw <= 8'd50;
        decodeHit <= 1'b1;
        repeat (4) @(posedge clk);
        run_cycle(1'b1, 2, 2);
        set_ctrl(bws_pkg::MODE_AUTO, 2'h1);
        run_cycle(1'b1, 1, 1);
        decodeHit <= 1'b0;
    endtask

    // hang guard well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        clkCount++;
        if (clkCount > 20000) begin
            err_total++;
            $display("ERROR %0t timeout", $time);
            stop_test();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        test_reset_gpio();
        test_fixed();
        test_pin();
        test_decode();
        stop_test();
    end
endmodule
